// ==== src/frj_core.sv ====
// execution unit for clear, complement, decrement, increment, skip and jump
`timescale 1ns/1ps
module frj_core
    import frj_pkg::*;
(
    input wire logic CORE_CLK, // instruction clock, 40 MHz
    input wire logic RESET_N, // asynchronous reset, active low
    input wire logic INSTR_VALID, // an instruction is presented this cycle
    input wire frj_op_t INSTR_OP, // decoded operation
    input wire logic [ADDR_W-1:0] INSTR_REG, // register index in window
    input wire logic INSTR_DEST, // 0 accumulator, 1 register
    input wire logic [IMM_W-1:0] INSTR_IMM, // jump target low bits
    input wire logic [1:0] PAGE_SEL, // status page-select bits 6:5
    input wire logic [DATA_W-1:0] ACC_IN, // software preload of the accumulator
    input wire logic ACC_LOAD, // load ACC_IN into the accumulator
    output logic [DATA_W-1:0] ACC, // accumulator
    output logic ZERO_FLAG, // status zero flag
    output logic [PC_W-1:0] PROGRAM_COUNTER, // program counter
    output logic BUSY, // second cycle of a two-cycle instruction
    output logic RETIRED, // pulse: an instruction completed
    output logic SKIPPED, // pulse: a fetched instruction was discarded
    output logic REG_WE, // pulse: data register written
    output logic [ADDR_W-1:0] REG_WADDR, // index of written register
    output logic [DATA_W-1:0] REG_WDATA // value written
);
    logic [DATA_W-1:0] regs [NUM_REGS];
    frj_state_t state;
    frj_state_t next_state;
    logic [DATA_W-1:0] src;
    logic [DATA_W-1:0] next_result;
    logic [DATA_W-1:0] next_acc;
    logic [PC_W-1:0] next_pc;
    logic next_is_zero;
    logic next_zero_flag;
    logic next_busy;
    logic next_retired;
    logic next_skipped;
    logic accept;
    logic flushing;
    logic is_clear;
    logic is_jump;
    logic is_skip;
    logic uses_dest;
    logic sets_zero;
    logic skip_now;
    logic to_register;
    logic to_accumulator;

    // an instruction offered during the flush slot is ignored
    assign flushing = (state == ST_FLUSH);
    assign accept = INSTR_VALID && !flushing;
    assign src = regs[INSTR_REG];

    assign is_clear = (INSTR_OP == OP_CLEAR);
    assign is_jump = (INSTR_OP == OP_JUMP);
    assign is_skip = (INSTR_OP == OP_DEC_SKIP) || (INSTR_OP == OP_INC_SKIP);

    // result of the operation on the addressed register
    always_comb begin
        unique case (INSTR_OP)
            OP_CLEAR: next_result = ZERO_BYTE;
            OP_COMPLEMENT: next_result = ~src;
            OP_DECREMENT: next_result = src - ONE_BYTE;
            OP_INCREMENT: next_result = src + ONE_BYTE;
            OP_DEC_SKIP: next_result = src - ONE_BYTE;
            OP_INC_SKIP: next_result = src + ONE_BYTE;
            OP_NONE: next_result = src;
            OP_JUMP: next_result = src;
        endcase
    end

    // which results go anywhere and which touch the zero flag
    always_comb begin
        unique case (INSTR_OP)
            OP_NONE: begin
                uses_dest = 1'b0;
                sets_zero = 1'b0;
            end
            OP_CLEAR: begin
                uses_dest = 1'b1;
                sets_zero = 1'b1;
            end
            OP_COMPLEMENT: begin
                uses_dest = 1'b1;
                sets_zero = 1'b1;
            end
            OP_DECREMENT: begin
                uses_dest = 1'b1;
                sets_zero = 1'b1;
            end
            OP_INCREMENT: begin
                uses_dest = 1'b1;
                sets_zero = 1'b1;
            end
            OP_DEC_SKIP: begin
                uses_dest = 1'b1;
                sets_zero = 1'b0;
            end
            OP_INC_SKIP: begin
                uses_dest = 1'b1;
                sets_zero = 1'b0;
            end
            OP_JUMP: begin
                uses_dest = 1'b0;
                sets_zero = 1'b0;
            end
        endcase
    end

    assign next_is_zero = (next_result == ZERO_BYTE);
    assign skip_now = is_skip && next_is_zero;

    // clear ignores the destination bit and always writes the register
    assign to_register = accept && uses_dest && (is_clear || (INSTR_DEST != DEST_ACC));
    assign to_accumulator = accept && uses_dest && !is_clear && (INSTR_DEST == DEST_ACC);

    // data memory holds no reset value; a location reads unknown until written
    always_ff @(posedge CORE_CLK) begin
        if (to_register) begin
            regs[INSTR_REG] <= next_result;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            REG_WE <= 1'b0;
        end else begin
            REG_WE <= to_register;
        end
    end

    // address and value of the last write stay until the next one
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            REG_WADDR <= '0;
            REG_WDATA <= ZERO_BYTE;
        end else if (to_register) begin
            REG_WADDR <= INSTR_REG;
            REG_WDATA <= next_result;
        end
    end

    // instruction results take priority over a software preload
    always_comb begin
        next_acc = ACC;
        if (to_accumulator) begin
            next_acc = next_result;
        end else if (ACC_LOAD) begin
            next_acc = ACC_IN;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ACC <= ZERO_BYTE;
        end else begin
            ACC <= next_acc;
        end
    end

    // skip variants, the jump and idle cycles leave the zero flag alone
    always_comb begin
        next_zero_flag = ZERO_FLAG;
        if (accept && sets_zero) begin
            next_zero_flag = next_is_zero;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ZERO_FLAG <= 1'b0;
        end else begin
            ZERO_FLAG <= next_zero_flag;
        end
    end

    // sequencing: jumps and taken skips add one flush slot
    always_comb begin
        next_state = state;
        next_pc = PROGRAM_COUNTER;
        next_busy = 1'b0;
        next_retired = 1'b0;
        next_skipped = 1'b0;
        unique case (state)
            ST_EXEC: begin
                if (accept) begin
                    if (is_jump) begin
                        next_pc = {PAGE_SEL, INSTR_IMM};
                        next_state = ST_FLUSH;
                        next_busy = 1'b1;
                    end else if (skip_now) begin
                        next_pc = PROGRAM_COUNTER + PC_ONE;
                        next_state = ST_FLUSH;
                        next_busy = 1'b1;
                    end else begin
                        next_pc = PROGRAM_COUNTER + PC_ONE;
                        next_retired = 1'b1;
                    end
                end
            end
            ST_FLUSH: begin
                // the prefetched word is discarded; a no-operation fills this cycle
                next_pc = PROGRAM_COUNTER + PC_ONE;
                next_state = ST_EXEC;
                next_retired = 1'b1;
                next_skipped = 1'b1;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state <= ST_EXEC;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            PROGRAM_COUNTER <= PC_RESET;
        end else begin
            PROGRAM_COUNTER <= next_pc;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            BUSY <= 1'b0;
        end else begin
            BUSY <= next_busy;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RETIRED <= 1'b0;
        end else begin
            RETIRED <= next_retired;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            SKIPPED <= 1'b0;
        end else begin
            SKIPPED <= next_skipped;
        end
    end
endmodule

// ==== src/frj_pkg.sv ====
// constants and types for the file register and jump execution block
package frj_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 5;
    localparam int PC_W = 11;
    localparam int IMM_W = 9;
    localparam int NUM_REGS = 32;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] ONE_BYTE = 8'h01;
    localparam logic [PC_W-1:0] PC_RESET = 11'h000;
    localparam logic [PC_W-1:0] PC_ONE = 11'h001;
    localparam logic [1:0] PAGE_RESET = 2'h0;
    localparam logic DEST_ACC = 1'b0;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_CLEAR = 3'b001,
        OP_COMPLEMENT = 3'b010,
        OP_DECREMENT = 3'b011,
        OP_INCREMENT = 3'b100,
        OP_DEC_SKIP = 3'b101,
        OP_INC_SKIP = 3'b110,
        OP_JUMP = 3'b111
    } frj_op_t;

    typedef enum logic [0:0] {
        ST_EXEC = 1'b0,
        ST_FLUSH = 1'b1
    } frj_state_t;
endpackage

// ==== verif/frj_core_bench.sv ====
// self-checking bench for the execution block
`timescale 1ns/1ps
module frj_core_bench
    import frj_pkg::*;
;
    logic CORE_CLK, RESET_N, INSTR_VALID, INSTR_DEST, ACC_LOAD, ZERO_FLAG, BUSY, RETIRED, SKIPPED, REG_WE;
    logic mb, nb, w, ret, sk, z, aw, v;
    frj_op_t INSTR_OP;
    logic [4:0] INSTR_REG, REG_WADDR, wa;
    logic [8:0] INSTR_IMM;
    logic [1:0] PAGE_SEL;
    logic [7:0] ACC_IN, ACC, REG_WDATA, acc, wd, res;
    logic [7:0] rf [32];
    logic [10:0] PROGRAM_COUNTER, pc;
    logic [17:0] e;
    logic [31:0] rnd;
    int seed, k, i, errors, tests_run;
    // corners: all-ones wrap, increment skip taken, decrement skip taken and not, jumps, boundary index
    logic [17:0] tab [10] = '{18'h11600, 18'h31600, 18'h29600, 18'h21a00, 18'h29800,
                             18'h381a5, 18'h381ff, 18'h19c00, 18'h09c00, 18'h27c00};
    frj_core frj_core_inst (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .INSTR_VALID(INSTR_VALID), .INSTR_OP(INSTR_OP),
        .INSTR_REG(INSTR_REG), .INSTR_DEST(INSTR_DEST), .INSTR_IMM(INSTR_IMM), .PAGE_SEL(PAGE_SEL), .ACC_IN(ACC_IN),
        .ACC_LOAD(ACC_LOAD), .ACC(ACC), .ZERO_FLAG(ZERO_FLAG), .PROGRAM_COUNTER(PROGRAM_COUNTER), .BUSY(BUSY),
        .RETIRED(RETIRED), .SKIPPED(SKIPPED), .REG_WE(REG_WE), .REG_WADDR(REG_WADDR), .REG_WDATA(REG_WDATA));
    function automatic logic [7:0] calc(input frj_op_t op, input logic [7:0] v);
        case (op)
            OP_CLEAR: return 8'h00;
            OP_COMPLEMENT: return ~v;
            OP_DECREMENT, OP_DEC_SKIP: return v - 8'h01;
            default: return v + 8'h01;
        endcase
    endfunction
    task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic step;
        {w, aw, nb} = 3'h0;
        {ret, sk} = {mb, mb};
        if (INSTR_VALID || mb) pc = pc + 11'h001;
        if (INSTR_VALID && !mb) begin
            if (INSTR_OP == OP_JUMP) begin
                pc = {PAGE_SEL, INSTR_IMM};
                nb = 1;
            end else if (INSTR_OP != OP_NONE) begin
                res = calc(INSTR_OP, rf[INSTR_REG]);
                if (INSTR_DEST || INSTR_OP == OP_CLEAR) begin
                    rf[INSTR_REG] = res;
                    {w, wd, wa} = {1'b1, res, INSTR_REG};
                end else {aw, acc} = {1'b1, res};
                if (INSTR_OP < OP_DEC_SKIP) z = res == 8'h00;
                else nb = res == 8'h00;
            end
            ret = !nb;
        end
        if (ACC_LOAD && !aw) acc = ACC_IN;
        mb = nb;
    endtask
    task automatic drive;
        rnd = $random(seed);
        e = k < 32 ? {3'h1, k[4:0], 10'h000} : k < 42 ? tab[k-32] : rnd[17:0];
        v = k < 42 || rnd[30:29] != 2'h0;
        INSTR_VALID <= v;
        INSTR_OP <= frj_op_t'(e[17:15]);
        {INSTR_REG, INSTR_DEST, INSTR_IMM} <= e[14:0];
        {PAGE_SEL, ACC_IN, ACC_LOAD} <= rnd[28:18];
        if (v && !mb) k++;
    endtask
    initial begin
        CORE_CLK = 0;
        forever #12.5 CORE_CLK = ~CORE_CLK;
    end
    initial begin
        #60000;
        errors++;
        end_of_test;
    end
    initial begin
        {seed, k, errors, tests_run} = {32'd60367, 96'h0};
        {RESET_N, INSTR_VALID, INSTR_DEST, ACC_LOAD, INSTR_REG, INSTR_IMM, PAGE_SEL, ACC_IN} = 0;
        {mb, z, acc, pc} = 0;
        INSTR_OP = OP_NONE;
        repeat (16) @(posedge CORE_CLK);
        RESET_N <= 1;
        @(posedge CORE_CLK);
        drive;
        for (i = 0; i < 460; i++) begin
            @(posedge CORE_CLK);
            step;
            drive;
            @(negedge CORE_CLK);
            chk(ACC, acc);
            chk(ZERO_FLAG, z);
            chk(PROGRAM_COUNTER, pc);
            chk({BUSY, RETIRED, SKIPPED, REG_WE}, {mb, ret, sk, w});
            if (w) chk({REG_WADDR, REG_WDATA}, {wa, wd});
        end
        end_of_test;
    end
endmodule

// ==== verif/frj_core_properties.sv ====
// concurrent checks on the execution block ports
`timescale 1ns/1ps
module frj_core_properties
    import frj_pkg::*;
(
    input wire logic CORE_CLK, // instruction clock
    input wire logic RESET_N, // asynchronous reset, active low
    input wire logic INSTR_VALID, // instruction presented
    input wire frj_op_t INSTR_OP, // decoded operation
    input wire logic INSTR_DEST, // destination bit
    input wire logic [IMM_W-1:0] INSTR_IMM, // jump target low bits
    input wire logic [1:0] PAGE_SEL, // page-select bits
    input wire logic [DATA_W-1:0] ACC, // accumulator
    input wire logic ZERO_FLAG, // zero flag
    input wire logic [PC_W-1:0] PROGRAM_COUNTER, // program counter
    input wire logic BUSY, // flush slot
    input wire logic RETIRED, // completion pulse
    input wire logic SKIPPED, // discard pulse
    input wire logic REG_WE, // register write pulse
    input wire logic [DATA_W-1:0] REG_WDATA // written value
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);
    wire go = INSTR_VALID && !BUSY;
    wire alu = go && INSTR_OP inside {OP_COMPLEMENT, OP_DECREMENT, OP_INCREMENT};
    wire skp = go && INSTR_OP inside {OP_DEC_SKIP, OP_INC_SKIP};
    wire jmp = go && INSTR_OP == OP_JUMP;
    clear_zero_a: assert property (go && INSTR_OP == OP_CLEAR |=> REG_WE && REG_WDATA == 8'h00 && ZERO_FLAG)
        else $error("clear did not write zero");
    dest_route_a: assert property (alu |=> REG_WE == $past(INSTR_DEST))
        else $error("result sent to wrong place");
    alu_flag_a: assert property (alu |=> ZERO_FLAG == (($past(INSTR_DEST) ? REG_WDATA : ACC) == 8'h00))
        else $error("zero flag wrong");
    skip_flag_a: assert property (skp |=> $stable(ZERO_FLAG))
        else $error("skip changed a flag");
    skip_taken_a: assert property (skp |=> BUSY == (($past(INSTR_DEST) ? REG_WDATA : ACC) == 8'h00))
        else $error("skip decision wrong");
    flush_end_a: assert property (BUSY |=> !BUSY && RETIRED && SKIPPED)
        else $error("flush slot wrong");
    jump_target_a: assert property (jmp |=> PROGRAM_COUNTER == {$past(PAGE_SEL), $past(INSTR_IMM)} && $stable(ZERO_FLAG))
        else $error("jump target wrong");
    jump_flush_a: assert property (jmp |=> BUSY && !RETIRED)
        else $error("jump not two cycles");
    single_cycle_a: assert property (alu || go && INSTR_OP == OP_CLEAR |=> RETIRED && !BUSY)
        else $error("operation not single cycle");
    cover property (skp ##1 BUSY);
    cover property (jmp);
    cover property (alu && INSTR_DEST);
endmodule
bind frj_core frj_core_properties frj_core_properties_inst (.*);
